// *** include/hesb_pkg.sv ***
// Constants and types for the host error status bank.
// Assumes a single clock domain and an outside serial front end.
// Function
// - Regulator one overheat sets bit four.
// - Regulator two overheat sets bit five.
// - Channels one to eight range flags.
// - Channels nine to sixteen range flags.
// - Sleep masks channels; twelve-fourteen optional; sixteen never.
// - Termination fuse inputs set bits two, three.
// - Core voltage mismatch sets bits four, five.
// - Diode faults set bits six, seven.
// - Any throttling sets throttle bit zero.
// - Active-time band sets one of bits 1-5.
// - Full-time throttling sets bit six.
// - Over user limit sets bit seven.
// - Only limit bit feeds summary error.
// - Second processor throttle register, same layout.
// - Writing one clears; zero leaves flag.
// - Flags stick; clear fails while condition persists.
// - Summary error is OR of non-throttle flags and limit bits.
// - Sleep state and optional masks gate events.

package hesb_pkg;

   // ==========================================================
   // Register offsets and reset value
   localparam logic [7:0] HESB_OFS_REGUL = 8'h48;
   localparam logic [7:0] HESB_OFS_VLO = 8'h49;
   localparam logic [7:0] HESB_OFS_VHI = 8'h4a;
   localparam logic [7:0] HESB_OFS_MISC = 8'h4b;
   localparam logic [7:0] HESB_OFS_CPU1 = 8'h4c;
   localparam logic [7:0] HESB_OFS_CPU2 = 8'h4d;
   localparam logic [7:0] HESB_RST_VAL = 8'h00;

   // ==========================================================
   // Field positions and implemented-bit masks
   localparam int HESB_REGUL1_BIT = 4;
   localparam int HESB_TERM_LSB = 2;
   localparam int HESB_MISM_LSB = 4;
   localparam int HESB_DIODE_LSB = 6;
   localparam int HESB_THR_ANY_BIT = 0;
   localparam int HESB_THR_BAND_LSB = 1;
   localparam int HESB_THR_FULL_BIT = 6;
   localparam int HESB_THR_LIM_BIT = 7;
   localparam int HESB_CHAN_OPT_LSB = 11;
   localparam logic [7:0] HESB_REGUL_MASK = 8'h30;
   localparam logic [7:0] HESB_MISC_MASK = 8'hfc;
   localparam logic [7:0] HESB_THR_SUM_MASK = 8'h80;
   localparam logic [15:0] HESB_CHAN_OPT = 16'h3800;
   localparam logic [15:0] HESB_CHAN_NEVER = 16'h8000;

   // ==========================================================
   // Throttle band edges in 1/256 steps of active time
   localparam logic [7:0] HESB_BAND1_TOP = 8'h20;
   localparam logic [7:0] HESB_BAND2_TOP = 8'h40;
   localparam logic [7:0] HESB_BAND3_TOP = 8'h80;
   localparam logic [7:0] HESB_BAND4_TOP = 8'hc0;

   // ==========================================================
   // Sleep states
   typedef enum logic [1:0] {
      HESB_S0 = 2'b00,
      HESB_S1 = 2'b01,
      HESB_S3 = 2'b10,
      HESB_S45 = 2'b11
   } hesb_sleep_t;

endpackage

// *** src/hesb_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pins and a free-running clock.
`timescale 1ns/1ps
`default_nettype none

module hesb_sync #(
   parameter int W = 1
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   import hesb_pkg::*;

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   // ==========================================================
   // Per-bit chain
   // A level counts only when the last two stages agree, so a
   // pulse shorter than two cycles is filtered out.
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            s1_ff[b] <= 1'b0;
            s2_ff[b] <= 1'b0;
            s3_ff[b] <= 1'b0;
            sync_o[b] <= 1'b0;
         end else if (ce_i) begin
            s1_ff[b] <= async_i[b];
            s2_ff[b] <= s1_ff[b];
            s3_ff[b] <= s2_ff[b];
            if (s2_ff[b] == s3_ff[b]) begin
               sync_o[b] <= s3_ff[b];
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** src/hesb_thr_class.sv ***
// Sorts one processor's throttle measurement into flag bits.
// Assumes measurement results arrive with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none

module hesb_thr_class (
   // Live pin and interval result
   input wire logic active_i,
   input wire logic done_i,
   input wire logic [7:0] pct_i,
   input wire logic full_i,
   input wire logic [7:0] limit_i,
   // Flags to set
   output logic [7:0] set_o
);
   import hesb_pkg::*;

   logic some;
   logic part;

   // ==========================================================
   // Classification
   always_comb begin
      some = done_i && (full_i || (pct_i != 8'h00));
      part = done_i && !full_i && (pct_i != 8'h00);
      set_o = 8'h00;
      set_o[HESB_THR_ANY_BIT] = active_i || some;
      if (part) begin
         // Bands are exclusive, one bit per interval.
         if (pct_i < HESB_BAND1_TOP) begin
            set_o[HESB_THR_BAND_LSB] = 1'b1;
         end else if (pct_i < HESB_BAND2_TOP) begin
            set_o[HESB_THR_BAND_LSB+1] = 1'b1;
         end else if (pct_i < HESB_BAND3_TOP) begin
            set_o[HESB_THR_BAND_LSB+2] = 1'b1;
         end else if (pct_i < HESB_BAND4_TOP) begin
            set_o[HESB_THR_BAND_LSB+3] = 1'b1;
         end else begin
            set_o[HESB_THR_BAND_LSB+4] = 1'b1;
         end
      end
      set_o[HESB_THR_FULL_BIT] = done_i && full_i;
      set_o[HESB_THR_LIM_BIT] = done_i && (full_i || (pct_i > limit_i));
   end

endmodule
`default_nettype wire

// *** src/hesb_top.sv ***
// Host error status bank: sticky write-one-to-clear flags.
// Assumes an outside serial slave turns bus cycles into
// one-cycle read and write strobes on the register port.
`timescale 1ns/1ps
`default_nettype none

module hesb_top (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Pins
   input wire logic regulator1_overheat_input_i,
   input wire logic regulator2_overheat_input_i,
   input wire logic termination1_input_i,
   input wire logic termination2_input_i,
   input wire logic cpu1_throttle_input_n_i,
   input wire logic cpu2_throttle_input_n_i,
   // Measurement results
   input wire logic [15:0] chan_out_of_range_i,
   input wire logic [1:0] core_volt_mismatch_i,
   input wire logic [1:0] diode_fault_i,
   input wire logic [1:0] throttle_done_i,
   input wire logic [1:0] throttle_full_i,
   input wire logic [7:0] cpu1_throttle_pct_i,
   input wire logic [7:0] cpu2_throttle_pct_i,
   input wire logic [7:0] cpu1_throttle_limit_i,
   input wire logic [7:0] cpu2_throttle_limit_i,
   // Sleep control
   input wire hesb_pkg::hesb_sleep_t sleep_state_i,
   input wire logic [4:0] opt_mask_s3_i,
   input wire logic [4:0] opt_mask_s45_i,
   // Summary and flag views
   output logic host_err_o,
   output logic [7:0] regul_flags_o,
   output logic [15:0] chan_flags_o,
   output logic [7:0] misc_flags_o,
   output logic [7:0] cpu1_flags_o,
   output logic [7:0] cpu2_flags_o
);
   import hesb_pkg::*;

   // ==========================================================
   // Declarations
   logic [3:0] pin_sync;
   logic [1:0] thr_act;
   logic asleep;
   logic [4:0] opt_blk;
   logic [15:0] chan_blk;
   logic ev_blk;
   logic [7:0] regul_set;
   logic [15:0] chan_set;
   logic [7:0] misc_set;
   logic [7:0] thr_set [2];
   logic [7:0] regul_clr;
   logic [7:0] vlo_clr;
   logic [7:0] vhi_clr;
   logic [7:0] misc_clr;
   logic [7:0] thr_clr [2];
   logic [7:0] regul_ff;
   logic [7:0] vlo_ff;
   logic [7:0] vhi_ff;
   logic [7:0] misc_ff;
   logic [7:0] thr_ff [2];
   logic [7:0] nxt_rdata;
   logic [7:0] pct [2];
   logic [7:0] lim [2];

   assign pct[0] = cpu1_throttle_pct_i;
   assign pct[1] = cpu2_throttle_pct_i;
   assign lim[0] = cpu1_throttle_limit_i;
   assign lim[1] = cpu2_throttle_limit_i;

   // ==========================================================
   // Pin synchronisers
   hesb_sync #(
      .W(4)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .async_i({termination2_input_i, termination1_input_i,
                regulator2_overheat_input_i, regulator1_overheat_input_i}),
      .sync_o(pin_sync)
   );

   // The throttle pins are active low; inverting them ahead of the
   // chain lets the cleared stages read as idle, so reset raises no
   // false throttle event.
   hesb_sync #(
      .W(2)
   ) u_thr_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .async_i({~cpu2_throttle_input_n_i, ~cpu1_throttle_input_n_i}),
      .sync_o(thr_act)
   );

   // ==========================================================
   // Sleep masking
   always_comb begin
      asleep = (sleep_state_i == HESB_S3) || (sleep_state_i == HESB_S45);
      case (sleep_state_i)
         HESB_S3: opt_blk = opt_mask_s3_i;
         HESB_S45: opt_blk = opt_mask_s45_i;
         default: opt_blk = 5'h00;
      endcase
      // Fixed masks apply in both deep states; channel sixteen and
      // the optional channels escape the fixed mask.
      chan_blk = 16'h0000;
      if (asleep) begin
         chan_blk = ~(HESB_CHAN_OPT | HESB_CHAN_NEVER);
         chan_blk = chan_blk | (16'(opt_blk[2:0]) << HESB_CHAN_OPT_LSB);
      end
      ev_blk = asleep;
   end

   // ==========================================================
   // Set terms
   always_comb begin
      regul_set = 8'h00;
      regul_set[HESB_REGUL1_BIT] = pin_sync[0] && !ev_blk;
      regul_set[HESB_REGUL1_BIT+1] = pin_sync[1] && !ev_blk;
      chan_set = chan_out_of_range_i & ~chan_blk;
      misc_set = 8'h00;
      misc_set[HESB_TERM_LSB] = pin_sync[2] && !ev_blk;
      misc_set[HESB_TERM_LSB+1] = pin_sync[3] && !ev_blk;
      misc_set[HESB_MISM_LSB] = core_volt_mismatch_i[0] && !ev_blk;
      misc_set[HESB_MISM_LSB+1] = core_volt_mismatch_i[1] && !ev_blk;
      misc_set[HESB_DIODE_LSB] = diode_fault_i[0] && !opt_blk[3];
      misc_set[HESB_DIODE_LSB+1] = diode_fault_i[1] && !opt_blk[4];
   end

   // ==========================================================
   // Write-one-to-clear decode
   // Only implemented bits take a clear, so reserved bits stay zero.
   always_comb begin
      regul_clr = 8'h00;
      vlo_clr = 8'h00;
      vhi_clr = 8'h00;
      misc_clr = 8'h00;
      thr_clr[0] = 8'h00;
      thr_clr[1] = 8'h00;
      if (reg_wr_i) begin
         case (reg_addr_i)
            HESB_OFS_REGUL: regul_clr = reg_wdata_i & HESB_REGUL_MASK;
            HESB_OFS_VLO: vlo_clr = reg_wdata_i;
            HESB_OFS_VHI: vhi_clr = reg_wdata_i;
            HESB_OFS_MISC: misc_clr = reg_wdata_i & HESB_MISC_MASK;
            HESB_OFS_CPU1: thr_clr[0] = reg_wdata_i;
            HESB_OFS_CPU2: thr_clr[1] = reg_wdata_i;
            default: regul_clr = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Regulator flags
   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         regul_ff <= HESB_RST_VAL;
      end else if (ce_i) begin
         regul_ff <= ((regul_ff & ~regul_clr) | regul_set) & HESB_REGUL_MASK;
      end
   end

   // ==========================================================
   // Voltage channel flags, low bank
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         vlo_ff <= HESB_RST_VAL;
      end else if (ce_i) begin
         vlo_ff <= (vlo_ff & ~vlo_clr) | chan_set[7:0];
      end
   end

   // ==========================================================
   // Voltage channel flags, high bank
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         vhi_ff <= HESB_RST_VAL;
      end else if (ce_i) begin
         vhi_ff <= (vhi_ff & ~vhi_clr) | chan_set[15:8];
      end
   end

   // ==========================================================
   // Fuse, mismatch and diode flags
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         misc_ff <= HESB_RST_VAL;
      end else if (ce_i) begin
         misc_ff <= ((misc_ff & ~misc_clr) | misc_set) & HESB_MISC_MASK;
      end
   end

   // ==========================================================
   // Throttle status, one register per processor
   for (genvar c = 0; c < 2; c++) begin : g_cpu
      logic [7:0] raw_set;

      hesb_thr_class u_class (
         .active_i(thr_act[c]),
         .done_i(throttle_done_i[c]),
         .pct_i(pct[c]),
         .full_i(throttle_full_i[c]),
         .limit_i(lim[c]),
         .set_o(raw_set)
      );

      // Throttle events are masked in both deep sleep states.
      assign thr_set[c] = ev_blk ? 8'h00 : raw_set;

      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            thr_ff[c] <= HESB_RST_VAL;
         end else if (ce_i) begin
            thr_ff[c] <= (thr_ff[c] & ~thr_clr[c]) | thr_set[c];
         end
      end
   end

   // ==========================================================
   // Summary error
   // The band bits are informational and must not raise the summary.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         host_err_o <= 1'b0;
      end else if (ce_i) begin
         host_err_o <= (|regul_ff) || (|vlo_ff) || (|vhi_ff) || (|misc_ff)
                       || (|(thr_ff[0] & HESB_THR_SUM_MASK))
                       || (|(thr_ff[1] & HESB_THR_SUM_MASK));
      end
   end

   // ==========================================================
   // Read path
   always_comb begin
      case (reg_addr_i)
         HESB_OFS_REGUL: nxt_rdata = regul_ff;
         HESB_OFS_VLO: nxt_rdata = vlo_ff;
         HESB_OFS_VHI: nxt_rdata = vhi_ff;
         HESB_OFS_MISC: nxt_rdata = misc_ff;
         HESB_OFS_CPU1: nxt_rdata = thr_ff[0];
         HESB_OFS_CPU2: nxt_rdata = thr_ff[1];
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else if (ce_i) begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
         end
      end
   end

   // ==========================================================
   // Flag views, one cycle behind the registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         regul_flags_o <= 8'h00;
         chan_flags_o <= 16'h0000;
         misc_flags_o <= 8'h00;
         cpu1_flags_o <= 8'h00;
         cpu2_flags_o <= 8'h00;
      end else if (ce_i) begin
         regul_flags_o <= regul_ff;
         chan_flags_o <= {vhi_ff, vlo_ff};
         misc_flags_o <= misc_ff;
         cpu1_flags_o <= thr_ff[0];
         cpu2_flags_o <= thr_ff[1];
      end
   end

endmodule
`default_nettype wire

// *** verification/hesb_checker.sv ***
// Checker for the host error status bank, bound to its top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hesb_checker
   import hesb_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   // Events
   input wire logic [15:0] chan_out_of_range_i,
   input wire logic [1:0] throttle_done_i,
   input wire logic [1:0] throttle_full_i,
   input wire hesb_pkg::hesb_sleep_t sleep_state_i,
   // Flag views
   input wire logic host_err_o,
   input wire logic [7:0] regul_flags_o,
   input wire logic [15:0] chan_flags_o,
   input wire logic [7:0] misc_flags_o,
   input wire logic [7:0] cpu1_flags_o,
   input wire logic [7:0] cpu2_flags_o
);
   logic [47:0] all_f;
   assign all_f = {regul_flags_o, chan_flags_o, misc_flags_o, cpu1_flags_o, cpu2_flags_o};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Sequences
   sequence s_rd;
      ce_i && reg_rd_i;
   endsequence
   sequence s_full1;
      ce_i && throttle_done_i[0] && throttle_full_i[0] && sleep_state_i == HESB_S0 ##1 ce_i;
   endsequence
   sequence s_ch16;
      ce_i && chan_out_of_range_i[15] ##1 ce_i;
   endsequence
   // ==========================================================
   // Properties
   property p_rvalid;
      s_rd |=> reg_rvalid_o;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read gave no valid");
   property p_no_rvalid;
      ce_i && !reg_rd_i |=> !reg_rvalid_o;
   endproperty
   a_no_rvalid: assert property (p_no_rvalid) else $error("valid without read");
   property p_resv_rd;
      s_rd ##0 reg_addr_i == HESB_OFS_MISC |=> reg_rdata_o[1:0] == 2'h0;
   endproperty
   a_resv_rd: assert property (p_resv_rd) else $error("reserved bits read set");
   property p_unmapped;
      s_rd ##0 reg_addr_i > HESB_OFS_CPU2 |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ch16;
      s_ch16 |=> chan_flags_o[15];
   endproperty
   a_ch16: assert property (p_ch16) else $error("channel 16 flag missed");
   property p_full;
      s_full1 |=> cpu1_flags_o[6] && cpu1_flags_o[7];
   endproperty
   a_full: assert property (p_full) else $error("full throttle flags missed");
   // A zero write must not disturb flags, so it counts as no write here.
   // The views trail the flags by a cycle, so the write must be absent a cycle earlier.
   property p_sticky;
      (!reg_wr_i || reg_wdata_i == 8'h00) ##1 1'b1 |=> (all_f & $past(all_f)) == $past(all_f);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
   property p_sum;
      host_err_o == (|{all_f[47:16], cpu1_flags_o[7], cpu2_flags_o[7]});
   endproperty
   a_sum: assert property (p_sum) else $error("summary error wrong");
   property p_resv;
      regul_flags_o[7:6] == 2'h0 && regul_flags_o[3:0] == 4'h0 && misc_flags_o[1:0] == 2'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved flag set");
endmodule
bind hesb_top hesb_checker u_chk (.clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i,
   .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .chan_out_of_range_i,
   .throttle_done_i, .throttle_full_i, .sleep_state_i, .host_err_o, .regul_flags_o,
   .chan_flags_o, .misc_flags_o, .cpu1_flags_o, .cpu2_flags_o);
`default_nettype wire

// *** verification/hesb_host.sv ***
// Host model: register strobes and sleep controls.
// Assumes callers run from the bench's falling-edge stimulus.
`timescale 1ns/1ps
`default_nettype none
module hesb_host (
   // Clock and answer
   input wire logic clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   // Requests
   output var logic [7:0] reg_addr_o = 8'h00,
   output var logic reg_wr_o = 1'h0,
   output var logic [7:0] reg_wdata_o = 8'h00,
   output var logic reg_rd_o = 1'h0,
   // Sleep controls
   output var hesb_pkg::hesb_sleep_t sleep_o = hesb_pkg::HESB_S0,
   output var logic [4:0] mask3_o = 5'h00,
   output var logic [4:0] mask45_o = 5'h00
);
   import hesb_pkg::*;
   // ==========================================================
   // Bus cycles
   // Released lines show the inverse so stale values cannot pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'h1;
      @(negedge clk_i);
      reg_wr_o = 1'h0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'h1;
      @(negedge clk_i);
      d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
      reg_rd_o = 1'h0;
      reg_addr_o = ~a;
   endtask
   task automatic set_sleep(input hesb_sleep_t s, input logic [4:0] m3, input logic [4:0] m45);
      @(negedge clk_i);
      sleep_o = s;
      mask3_o = m3;
      mask45_o = m45;
   endtask
endmodule
`default_nettype wire

// *** verification/host_error_status_bank_tb.sv ***
// Self-checking bench for the host error status bank.
// Assumes the host model and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module host_error_status_bank_tb;
   import hesb_pkg::*;
   typedef struct packed {
      logic [5:0] pins;
      logic [15:0] chan;
      logic [1:0] mism;
      logic [1:0] diode;
      logic [7:0] pct;
      logic full;
      logic [7:0] lim;
      logic [47:0] want;
      logic err;
   } hesb_row_t;
   // Pins are {thr2, thr1, term2, term1, reg2, reg1}; want runs 48h to 4Dh.
   localparam hesb_row_t ROWS [7] = '{
      '{6'h01, 16'h0001, 2'h1, 2'h0, 8'h10, 1'h0, 8'hff, 48'h10_01_00_10_03_03, 1'h1},
      '{6'h02, 16'h8100, 2'h2, 2'h1, 8'h20, 1'h0, 8'h20, 48'h20_00_81_60_05_05, 1'h1},
      '{6'h04, 16'h0080, 2'h0, 2'h2, 8'h40, 1'h0, 8'h3f, 48'h00_80_00_84_89_89, 1'h1},
      '{6'h00, 16'h0000, 2'h0, 2'h0, 8'hbf, 1'h0, 8'hff, 48'h00_00_00_00_11_11, 1'h0},
      '{6'h08, 16'h00fe, 2'h0, 2'h0, 8'hc0, 1'h0, 8'hff, 48'h00_fe_00_08_21_21, 1'h1},
      '{6'h00, 16'h7e00, 2'h0, 2'h0, 8'hff, 1'h1, 8'hff, 48'h00_00_7e_00_c1_c1, 1'h1},
      '{6'h30, 16'h0000, 2'h0, 2'h0, 8'h00, 1'h0, 8'h00, 48'h00_00_00_00_01_01, 1'h0}
   };
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic ce = 1'h1;
   logic [5:0] pins = 6'h00;
   logic [15:0] chan = 16'h0000;
   logic [1:0] mism = 2'h0;
   logic [1:0] diode = 2'h0;
   logic [1:0] done = 2'h0;
   logic [1:0] full = 2'h0;
   logic [7:0] pct = 8'h00;
   logic [7:0] lim = 8'h00;
   logic [7:0] addr, wdata, rdata, d, regul, misc, cpu1, cpu2;
   logic [15:0] chanf;
   logic [4:0] m3, m45;
   logic wr, rd, rvalid, host_err;
   hesb_sleep_t sleep;
   hesb_row_t row;
   int fails = 0;
   int n_compared = 0;
   always #2.5 clk = ~clk;
   hesb_host host (.clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd), .sleep_o(sleep), .mask3_o(m3),
      .mask45_o(m45));
   hesb_top dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .regulator1_overheat_input_i(pins[0]), .regulator2_overheat_input_i(pins[1]),
      .termination1_input_i(pins[2]), .termination2_input_i(pins[3]),
      .cpu1_throttle_input_n_i(~pins[4]), .cpu2_throttle_input_n_i(~pins[5]),
      .chan_out_of_range_i(chan), .core_volt_mismatch_i(mism), .diode_fault_i(diode),
      .throttle_done_i(done), .throttle_full_i(full), .cpu1_throttle_pct_i(pct),
      .cpu2_throttle_pct_i(pct), .cpu1_throttle_limit_i(lim), .cpu2_throttle_limit_i(lim),
      .sleep_state_i(sleep), .opt_mask_s3_i(m3), .opt_mask_s45_i(m45), .host_err_o(host_err),
      .regul_flags_o(regul), .chan_flags_o(chanf), .misc_flags_o(misc), .cpu1_flags_o(cpu1),
      .cpu2_flags_o(cpu2));
   // ==========================================================
   // Tasks
   task automatic check(input logic [47:0] seen, input logic [47:0] want);
      n_compared++;
      if (seen !== want) begin
         fails++;
         $display("mismatch at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic read_all(input logic [47:0] want);
      for (int i = 0; i < 6; i++) begin
         host.rd(HESB_OFS_REGUL + 8'(i), d);
         check(d, want[47-8*i -: 8]);
      end
   endtask
   task automatic clear_all;
      for (int i = 0; i < 6; i++) begin
         host.wr(HESB_OFS_REGUL + 8'(i), 8'hff);
      end
      tick(2);
   endtask
   task automatic close_out;
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Sequence
   // Pins pass a synchroniser, so they are held and flushed for six cycles each.
   initial begin
      tick(5);
      rst_n = 1'h1;
      foreach (ROWS[r]) begin
         row = ROWS[r];
         {pins, chan, mism, diode, pct, lim} = {row.pins, row.chan, row.mism, row.diode,
            row.pct, row.lim};
         full = {2{row.full}};
         done = 2'h3;
         tick(1);
         {chan, mism, diode, done} = '0;
         tick(5);
         pins = 6'h00;
         tick(6);
         read_all(row.want);
         check(host_err, row.err);
         clear_all();
         check({regul, chanf, misc, cpu1, cpu2}, '0);
      end
      chan = 16'h0001;
      tick(2);
      host.wr(HESB_OFS_VLO, 8'h01);
      host.rd(HESB_OFS_VLO, d);
      check(d, 8'h01);
      chan = 16'h0000;
      host.wr(HESB_OFS_VLO, 8'h00);
      host.rd(HESB_OFS_VLO, d);
      check(d, 8'h01);
      host.wr(HESB_OFS_VLO, 8'h01);
      host.rd(HESB_OFS_VLO, d);
      check(d, 8'h00);
      for (int k = 0; k < 2; k++) begin
         host.set_sleep(k ? HESB_S45 : HESB_S3, 5'h00, 5'h1f);
         {pins, chan, mism, diode, done} = {6'h3f, 16'hffff, 2'h3, 2'h3, 2'h3};
         pct = 8'h40;
         tick(1);
         done = 2'h0;
         tick(5);
         {pins, chan, mism, diode} = '0;
         tick(6);
         host.set_sleep(HESB_S0, 5'h00, 5'h00);
         read_all(k ? 48'h00_00_80_00_00_00 : 48'h00_00_b8_c0_00_00);
         clear_all();
      end
      // A frozen enable must let no event reach the flags.
      ce = 1'h0;
      chan = 16'h0002;
      tick(2);
      ce = 1'h1;
      chan = 16'h0000;
      host.rd(HESB_OFS_VLO, d);
      check(d, 8'h00);
      host.wr(8'h50, 8'hff);
      host.rd(8'h50, d);
      check(d, 8'h00);
      chan = 16'h8001;
      tick(2);
      chan = 16'h0000;
      rst_n = 1'h0;
      tick(5);
      rst_n = 1'h1;
      check({regul, chanf, misc, cpu1, cpu2}, '0);
      host.rd(HESB_OFS_VHI, d);
      check(d, 8'h00);
      close_out();
   end
   // The run needs well under a thousand cycles; this leaves a wide margin.
   initial begin
      #100000;
      fails++;
      close_out();
   end
endmodule
`default_nettype wire
